// File: src/dsci_core.sv
// Operation
// - Commands and address are sampled on the rising clock edge.
// - Burst data moves two words per clock, rise and fall beats.
// - Bursts start at the given column and run 2, 4 or 8 beats.
// - Address bit 10 with read/write starts self-timed precharge after the burst.
// - Activate takes 14-bit row; read/write takes 10-bit column.
// - Two bank-select inputs pick one of four banks.
// - Chip select high masks every command; it is part of the code.
// - Clock gate low freezes data outputs and burst address from the next cycle.
// - Clock gate low with all banks idle enters power-down or self refresh.
// - Row strobe low, column and write strobes high: activate the bank.
// - Row and write strobes low, column high: precharge, bank goes idle.
// - Read latency is 2, 2.5 or 3 clocks, set by mode.
// - Burst order is sequential or interleaved by mode.
// - Byte masks act on the same beat they accompany.
// - Extended mode programming turns the delay-locked loop on or off.
// - Four independent banks of 16M words by 16 bits.
// - Column strobe low, row high: read if write strobe high, else write.
// - Masked byte lanes are discarded; lower mask bits 0-7, upper 8-15.
`default_nettype none
module dsci_core (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic cke_in,
    input wire logic cs_b_in,
    input wire logic ras_b_in,
    input wire logic cas_b_in,
    input wire logic we_b_in,
    input wire logic bank_sel_bit0_in,
    input wire logic bank_sel_bit1_in,
    input wire logic [dsci_pkg::ROW_W-1:0] addr_in,
    input wire logic [dsci_pkg::DQ_W-1:0] dq_rise_in,
    input wire logic [dsci_pkg::DQ_W-1:0] dq_fall_in,
    input wire logic [1:0] lower_byte_mask_in,
    input wire logic [1:0] upper_byte_mask_in,
    input wire logic mode_program_in,
    input wire logic [2:0] burst_len_code_in,
    input wire logic burst_interleave_in,
    input wire logic [2:0] cas_lat_code_in,
    input wire logic extended_mode_program_in,
    input wire logic dll_enable_in,
    output logic [dsci_pkg::DQ_W-1:0] dq_rise_out,
    output logic [dsci_pkg::DQ_W-1:0] dq_fall_out,
    output logic [1:0] dq_oe_out,
    output logic [dsci_pkg::NUM_BANKS-1:0] bank_active_out,
    output logic all_idle_out,
    output logic power_down_out,
    output logic self_refresh_out,
    output logic dll_on_out,
    output logic wr_ready_out
);
    localparam int NB = dsci_pkg::NUM_BANKS;
    localparam int MW = dsci_pkg::MEM_IDX_W;
    localparam int CW = dsci_pkg::COL_W;
    localparam int TRP_WAIT = dsci_pkg::TRP_CYC;

    function automatic logic [2:0] bl_mask(input logic [2:0] code);
        case (code)
            dsci_pkg::BL2_CODE: bl_mask = dsci_pkg::BL2_MASK;
            dsci_pkg::BL4_CODE: bl_mask = dsci_pkg::BL4_MASK;
            default: bl_mask = dsci_pkg::BL8_MASK;
        endcase
    endfunction

    // Burst only wraps inside the aligned block of its length
    function automatic logic [CW-1:0] burst_col(input logic [CW-1:0] start, input logic [2:0] beat,
                                                input logic [2:0] code, input logic ilv);
        logic [CW-1:0] m;
        logic [2:0] low;
        m = {{(CW-3){1'b0}}, bl_mask(code)};
        low = (ilv == dsci_pkg::BT_INTERLEAVE) ? (start[2:0] ^ beat) : (start[2:0] + beat);
        burst_col = (start & ~m) | ({{(CW-3){1'b0}}, low} & m);
    endfunction

    function automatic logic [MW-1:0] mem_index(input logic [1:0] bank, input logic [dsci_pkg::ROW_W-1:0] row,
                                                input logic [CW-1:0] col);
        mem_index = {bank, row[dsci_pkg::IDX_ROW_W-1:0], col[dsci_pkg::IDX_COL_W-1:0]};
    endfunction

    logic cke_reg;
    logic run;
    logic [3:0] cmd_code;
    logic cmd_ok;
    logic act_go;
    logic pre_go;
    logic rd_go;
    logic wr_go;
    logic ref_go;
    logic [1:0] bank_idx;
    logic [2:0] bl_code_reg;
    logic ilv_reg;
    logic [2:0] cl_code_reg;
    logic [NB-1:0] bank_active_reg;
    logic [dsci_pkg::ROW_W-1:0] bank_row_reg [0:NB-1];
    logic [NB-1:0] pre_busy;
    logic all_idle_now;
    logic burst_on_reg;
    logic burst_wr_reg;
    logic burst_ap_reg;
    logic [1:0] burst_bank_reg;
    logic [CW-1:0] burst_col_reg;
    logic [dsci_pkg::PAIR_W-1:0] pair_reg;
    logic burst_last;
    logic [2:0] len_mask;
    logic adv;
    logic ap_fire;
    logic [CW-1:0] col_rise;
    logic [CW-1:0] col_fall;
    logic [MW-1:0] idx_rise;
    logic [MW-1:0] idx_fall;
    logic fifo_ready;
    logic wr_push;
    dsci_pkg::dsci_wr_entry_t push_entry;
    dsci_pkg::dsci_wr_entry_t drain_entry;
    logic drain_valid;
    logic drain_half_reg;
    logic [MW-1:0] drain_idx;
    logic [dsci_pkg::DQ_W-1:0] drain_word;
    logic [dsci_pkg::LANES-1:0] drain_mask;
    dsci_pkg::dsci_pair_t gen_pair;
    dsci_pkg::dsci_pair_t pipe1_reg;
    dsci_pkg::dsci_pair_t pipe2_reg;
    logic valid1_reg;
    logic valid2_reg;
    dsci_pkg::dsci_pwr_t pwr_reg;

    assign run = cke_reg;
    assign cmd_code = {cs_b_in, ras_b_in, cas_b_in, we_b_in};
    assign cmd_ok = run && !cs_b_in;
    assign act_go = cmd_ok && (cmd_code == dsci_pkg::CMD_ACT);
    assign pre_go = cmd_ok && (cmd_code == dsci_pkg::CMD_PRE);
    assign rd_go = cmd_ok && (cmd_code == dsci_pkg::CMD_RD);
    assign wr_go = cmd_ok && (cmd_code == dsci_pkg::CMD_WR);
    assign ref_go = cmd_ok && (cmd_code == dsci_pkg::CMD_REF);
    assign bank_idx = {bank_sel_bit1_in, bank_sel_bit0_in};
    assign all_idle_now = (bank_active_reg == '0) && (pre_busy == '0);

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cke_reg <= 1'b0;
            bl_code_reg <= dsci_pkg::BL2_CODE;
            ilv_reg <= 1'b0;
            cl_code_reg <= dsci_pkg::CL2_CODE;
            dll_on_out <= 1'b0;
        end else begin
            cke_reg <= cke_in;
            if (mode_program_in) begin
                bl_code_reg <= burst_len_code_in;
                ilv_reg <= burst_interleave_in;
                cl_code_reg <= cas_lat_code_in;
            end
            if (extended_mode_program_in) begin
                dll_on_out <= dll_enable_in;
            end
        end
    end

    // Independent bank state machines; NOP touches none of them
    generate
        for (genvar b = 0; b < NB; b++) begin : g_bank
            logic [dsci_pkg::PRE_CNT_W-1:0] pre_cnt_reg;
            assign pre_busy[b] = (pre_cnt_reg != '0);
            always_ff @(posedge clk_in) begin
                if (!rst_b_in) begin
                    bank_active_reg[b] <= 1'b0;
                    bank_row_reg[b] <= '0;
                    pre_cnt_reg <= '0;
                end else if (run) begin
                    if (act_go && bank_idx == 2'(b) && !bank_active_reg[b] && !pre_busy[b]) begin
                        bank_active_reg[b] <= 1'b1;
                        bank_row_reg[b] <= addr_in;
                    end else if ((pre_go && bank_idx == 2'(b)) || (ap_fire && burst_bank_reg == 2'(b))) begin
                        bank_active_reg[b] <= 1'b0;
                        pre_cnt_reg <= dsci_pkg::PRE_CNT_W'(dsci_pkg::TRP_CYC);
                    end else if (pre_busy[b]) begin
                        pre_cnt_reg <= pre_cnt_reg - 1'b1;
                    end
                end
            end
        end
    endgenerate

    assign len_mask = bl_mask(bl_code_reg);
    assign burst_last = (pair_reg == len_mask[2:1]);
    // Write bursts wait for buffer room rather than drop beats
    assign adv = run && burst_on_reg && (!burst_wr_reg || fifo_ready);
    assign ap_fire = adv && burst_last && burst_ap_reg;

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            burst_on_reg <= 1'b0;
            burst_wr_reg <= 1'b0;
            burst_ap_reg <= 1'b0;
            burst_bank_reg <= '0;
            burst_col_reg <= '0;
            pair_reg <= '0;
        end else if (rd_go || wr_go) begin
            burst_on_reg <= 1'b1;
            burst_wr_reg <= wr_go;
            burst_ap_reg <= addr_in[dsci_pkg::AP_BIT];
            burst_bank_reg <= bank_idx;
            burst_col_reg <= addr_in[CW-1:0];
            pair_reg <= '0;
        end else if (adv) begin
            if (burst_last) begin
                burst_on_reg <= 1'b0;
            end else begin
                pair_reg <= pair_reg + 1'b1;
            end
        end
    end

    assign col_rise = burst_col(burst_col_reg, {pair_reg, 1'b0}, bl_code_reg, ilv_reg);
    assign col_fall = burst_col(burst_col_reg, {pair_reg, 1'b1}, bl_code_reg, ilv_reg);
    assign idx_rise = mem_index(burst_bank_reg, bank_row_reg[burst_bank_reg], col_rise);
    assign idx_fall = mem_index(burst_bank_reg, bank_row_reg[burst_bank_reg], col_fall);

    assign wr_push = adv && burst_wr_reg;
    always_comb begin
        push_entry.idx_rise = idx_rise;
        push_entry.idx_fall = idx_fall;
        push_entry.data.rise = dq_rise_in;
        push_entry.data.fall = dq_fall_in;
        push_entry.mask_rise = {upper_byte_mask_in[0], lower_byte_mask_in[0]};
        push_entry.mask_fall = {upper_byte_mask_in[1], lower_byte_mask_in[1]};
    end

    dsci_fifo #(
        .WIDTH($bits(dsci_pkg::dsci_wr_entry_t)),
        .DEPTH(dsci_pkg::FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .in_valid_in(wr_push),
        .in_ready_out(fifo_ready),
        .in_data_in(push_entry),
        .out_valid_out(drain_valid),
        .out_ready_in(drain_half_reg),
        .out_data_out(drain_entry)
    );
    assign wr_ready_out = fifo_ready;

    // Storage takes one beat per clock, so the buffer fills under long write runs
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            drain_half_reg <= 1'b0;
        end else if (drain_valid) begin
            drain_half_reg <= !drain_half_reg;
        end
    end
    assign drain_idx = drain_half_reg ? drain_entry.idx_fall : drain_entry.idx_rise;
    assign drain_word = drain_half_reg ? drain_entry.data.fall : drain_entry.data.rise;
    assign drain_mask = drain_half_reg ? drain_entry.mask_fall : drain_entry.mask_rise;

    generate
        for (genvar l = 0; l < dsci_pkg::LANES; l++) begin : g_lane
            logic [dsci_pkg::LANE_W-1:0] lane_mem [0:(2**MW)-1];
            logic [dsci_pkg::LANE_W-1:0] lane_old;
            always_ff @(posedge clk_in) begin
                if (drain_valid && !drain_mask[l]) begin
                    lane_mem[drain_idx] <= drain_word[l*dsci_pkg::LANE_W +: dsci_pkg::LANE_W];
                end
            end
            assign lane_old = lane_mem[drain_idx];
            assign gen_pair.rise[l*dsci_pkg::LANE_W +: dsci_pkg::LANE_W] = lane_mem[idx_rise];
            assign gen_pair.fall[l*dsci_pkg::LANE_W +: dsci_pkg::LANE_W] = lane_mem[idx_fall];
            a_lane_masked: assert property (@(posedge clk_in) disable iff (!rst_b_in)
                drain_valid && drain_mask[l] |=> lane_mem[$past(drain_idx)] == $past(lane_old))
                else $error("masked lane was written");
            a_lane_written: assert property (@(posedge clk_in) disable iff (!rst_b_in)
                drain_valid && !drain_mask[l] |=>
                lane_mem[$past(drain_idx)] == $past(drain_word[l*dsci_pkg::LANE_W +: dsci_pkg::LANE_W]))
                else $error("unmasked lane lost its data");
        end
    endgenerate

    // Read pipeline in half-cycle slots; output frozen while the clock gate is low
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            pipe1_reg <= '0;
            pipe2_reg <= '0;
            valid1_reg <= 1'b0;
            valid2_reg <= 1'b0;
            dq_rise_out <= '0;
            dq_fall_out <= '0;
            dq_oe_out <= '0;
        end else if (run) begin
            pipe1_reg <= gen_pair;
            valid1_reg <= burst_on_reg && !burst_wr_reg;
            pipe2_reg <= pipe1_reg;
            valid2_reg <= valid1_reg;
            case (cl_code_reg)
                dsci_pkg::CL3_CODE: begin
                    dq_rise_out <= pipe2_reg.rise;
                    dq_fall_out <= pipe2_reg.fall;
                    dq_oe_out <= {2{valid2_reg}};
                end
                dsci_pkg::CL25_CODE: begin
                    dq_rise_out <= pipe2_reg.fall;
                    dq_fall_out <= pipe1_reg.rise;
                    dq_oe_out <= {valid1_reg, valid2_reg};
                end
                default: begin
                    dq_rise_out <= pipe1_reg.rise;
                    dq_fall_out <= pipe1_reg.fall;
                    dq_oe_out <= {2{valid1_reg}};
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            bank_active_out <= '0;
            all_idle_out <= 1'b1;
        end else begin
            bank_active_out <= bank_active_reg;
            all_idle_out <= all_idle_now;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            pwr_reg <= dsci_pkg::DSCI_PWR_RUN;
        end else begin
            case (pwr_reg)
                dsci_pkg::DSCI_PWR_RUN: begin
                    if (cke_reg && !cke_in && all_idle_now) begin
                        pwr_reg <= ref_go ? dsci_pkg::DSCI_PWR_SELF : dsci_pkg::DSCI_PWR_DOWN;
                    end
                end
                dsci_pkg::DSCI_PWR_DOWN, dsci_pkg::DSCI_PWR_SELF: begin
                    if (cke_in) begin
                        pwr_reg <= dsci_pkg::DSCI_PWR_RUN;
                    end
                end
                default: pwr_reg <= dsci_pkg::DSCI_PWR_RUN;
            endcase
        end
    end
    assign power_down_out = pwr_reg[dsci_pkg::PWR_DOWN_BIT];
    assign self_refresh_out = pwr_reg[dsci_pkg::PWR_SELF_BIT];

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    a_act_opens: assert property (act_go && !bank_active_reg[bank_idx] && !pre_busy[bank_idx]
        ##1 1'b1 |=> bank_active_out[$past(bank_idx, 2)])
        else $error("activate did not open bank");
    a_pre_closes: assert property (pre_go |=> !bank_active_reg[$past(bank_idx)] ##TRP_WAIT
        !pre_busy[$past(bank_idx, TRP_WAIT + 1)])
        else $error("precharge did not return bank to idle");
    a_cs_masks: assert property (cs_b_in |=> (bank_active_reg & ~$past(bank_active_reg)) == '0
        && $stable(burst_col_reg))
        else $error("command taken with chip select high");
    a_nop_holds: assert property (cmd_ok && cmd_code == dsci_pkg::CMD_NOP && !ap_fire && pre_busy == '0
        |=> $stable(bank_active_reg))
        else $error("no-operation changed bank state");
    a_freeze_burst: assert property (!cke_reg && !rd_go && !wr_go |=> $stable(pair_reg)
        && $stable(dq_oe_out))
        else $error("burst moved while clock gated");
    a_cl2_latency: assert property ((rd_go && cl_code_reg == dsci_pkg::CL2_CODE && !mode_program_in)
        ##1 (cke_reg && !mode_program_in) [*2] |=> dq_oe_out == 2'b11)
        else $error("read data not at latency two");
    a_cl3_latency: assert property ((rd_go && cl_code_reg == dsci_pkg::CL3_CODE && !mode_program_in)
        ##1 (cke_reg && !mode_program_in) [*3] |=> dq_oe_out == 2'b11)
        else $error("read data not at latency three");
    a_ap_closes: assert property (ap_fire |=> !bank_active_reg[$past(burst_bank_reg)]
        && pre_busy[$past(burst_bank_reg)])
        else $error("auto precharge did not start");
    a_burst_len: assert property (burst_on_reg |-> pair_reg <= len_mask[2:1])
        else $error("burst ran past its length");
    a_pd_entry: assert property (pwr_reg == dsci_pkg::DSCI_PWR_RUN && cke_reg && !cke_in && all_idle_now
        && !ref_go |=> power_down_out)
        else $error("power-down not entered");
    a_dll_prog: assert property (extended_mode_program_in |=> dll_on_out == $past(dll_enable_in))
        else $error("delay-locked loop setting not taken");

    c_read_burst: cover property (rd_go ##[1:8] dq_oe_out == 2'b11);
    c_write_full: cover property (wr_push ##1 !fifo_ready);
    c_auto_pre: cover property (ap_fire);
    c_self_ref: cover property (self_refresh_out);
endmodule
`default_nettype wire

// File: inc/dsci_pkg.sv
`default_nettype none
package dsci_pkg;
    localparam int ROW_W = 14;
    localparam int COL_W = 10;
    localparam int BANK_W = 2;
    localparam int NUM_BANKS = 4;
    localparam int DQ_W = 16;
    localparam int LANE_W = 8;
    localparam int LANES = 2;
    localparam int AP_BIT = 10;
    localparam int BEAT_W = 3;
    localparam int PAIR_W = 2;
    // Storage keeps only a window of each bank; full depth is 2**(ROW_W+COL_W) words
    localparam int IDX_ROW_W = 2;
    localparam int IDX_COL_W = 4;
    localparam int MEM_IDX_W = BANK_W + IDX_ROW_W + IDX_COL_W;
    localparam int FIFO_DEPTH = 32;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [2:0] BL2_CODE = 3'h1;
    localparam logic [2:0] BL4_CODE = 3'h2;
    localparam logic [2:0] BL8_CODE = 3'h3;
    localparam logic [2:0] BL2_MASK = 3'h1;
    localparam logic [2:0] BL4_MASK = 3'h3;
    localparam logic [2:0] BL8_MASK = 3'h7;
    localparam logic [2:0] CL2_CODE = 3'h2;
    localparam logic [2:0] CL3_CODE = 3'h3;
    localparam logic [2:0] CL25_CODE = 3'h6;
    localparam logic BT_INTERLEAVE = 1'b1;
    localparam int CLK_NS = 100;
    localparam int TRP_NS = 20;
    localparam int TRP_CYC_RAW = (TRP_NS + CLK_NS - 1) / CLK_NS;
    localparam int TRP_CYC = (TRP_CYC_RAW < 1) ? 1 : TRP_CYC_RAW;
    localparam int PRE_CNT_W = 4;
    localparam int PWR_RUN_BIT = 0;
    localparam int PWR_DOWN_BIT = 1;
    localparam int PWR_SELF_BIT = 2;
    typedef enum logic [2:0] {
        DSCI_PWR_RUN = 3'b001,
        DSCI_PWR_DOWN = 3'b010,
        DSCI_PWR_SELF = 3'b100
    } dsci_pwr_t;
    typedef struct packed {
        logic [DQ_W-1:0] rise;
        logic [DQ_W-1:0] fall;
    } dsci_pair_t;
    typedef struct packed {
        logic [MEM_IDX_W-1:0] idx_rise;
        logic [MEM_IDX_W-1:0] idx_fall;
        dsci_pair_t data;
        logic [LANES-1:0] mask_rise;
        logic [LANES-1:0] mask_fall;
    } dsci_wr_entry_t;
endpackage
`default_nettype wire

// File: src/dsci_fifo.sv
`default_nettype none
module dsci_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store_reg [0:DEPTH-1];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic [AW:0] count_next;
    logic push;
    logic pop;

    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_valid_out = (count_reg != '0);
    assign out_data_out = store_reg[rd_ptr_reg];

    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            in_ready_out <= 1'b1;
        end else begin
            count_reg <= count_next;
            // Registered ready: full is known one cycle ahead
            in_ready_out <= (count_next < (AW+1)'(DEPTH));
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            store_reg[wr_ptr_reg] <= in_data_in;
        end
    end
endmodule
`default_nettype wire

// File: sim/dsci_ctrl_model.sv
`default_nettype none
module dsci_ctrl_model (
    input wire logic clk_in,
    output logic cke_out,
    output logic [3:0] cmd_out,
    output logic [1:0] bank_out,
    output logic [13:0] addr_out,
    output logic [15:0] rise_out,
    output logic [15:0] fall_out,
    output logic [1:0] lmask_out,
    output logic [1:0] umask_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {cke_out, cmd_out, bank_out, addr_out, rise_out, fall_out, lmask_out, umask_out} = {1'b1, 4'h7, 52'h0};
    end
    // Everything moves just after the edge, so the device samples a settled bus
    task automatic drive(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a,
                         input logic [15:0] r, input logic [15:0] f, input logic [1:0] l, input logic [1:0] u);
        @(posedge clk_in);
        #1;
        cmd_out = c;
        bank_out = b;
        addr_out = a;
        {rise_out, fall_out} = {r, f};
        {lmask_out, umask_out} = {l, u};
    endtask
endmodule
`default_nettype wire

// File: sim/dsci_core_test.sv
`default_nettype none
module dsci_core_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic pgm = 1'b0, ilv = 1'b0, emode = 1'b0, dll_en = 1'b1;
    logic [2:0] bl = 3'h1, cl = 3'h2;
    logic cke, idle, pd, sr, dll_on, wrdy;
    logic [3:0] cmd, act;
    logic [1:0] ba, lm, um, oe;
    logic [13:0] addr;
    logic [15:0] r, f, dq_r, dq_f;
    int num_errors = 0;
    int checks = 0;
    always #50 clk_in = ~clk_in;
    dsci_ctrl_model m (.clk_in(clk_in), .cke_out(cke), .cmd_out(cmd), .bank_out(ba), .addr_out(addr),
        .rise_out(r), .fall_out(f), .lmask_out(lm), .umask_out(um));
    dsci_core uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .cke_in(cke), .cs_b_in(cmd[3]), .ras_b_in(cmd[2]),
        .cas_b_in(cmd[1]), .we_b_in(cmd[0]), .bank_sel_bit0_in(ba[0]), .bank_sel_bit1_in(ba[1]),
        .addr_in(addr), .dq_rise_in(r), .dq_fall_in(f), .lower_byte_mask_in(lm), .upper_byte_mask_in(um),
        .mode_program_in(pgm), .burst_len_code_in(bl), .burst_interleave_in(ilv), .cas_lat_code_in(cl),
        .extended_mode_program_in(emode), .dll_enable_in(dll_en), .dq_rise_out(dq_r), .dq_fall_out(dq_f),
        .dq_oe_out(oe), .bank_active_out(act), .all_idle_out(idle), .power_down_out(pd),
        .self_refresh_out(sr), .dll_on_out(dll_on), .wr_ready_out(wrdy));
    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Idle data lines flip every cycle so stale beats never look valid
    task automatic op(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a);
        m.drive(c, b, a, ~r, ~f, 2'b00, 2'b00);
    endtask
    task automatic nop(input int n);
        repeat (n) op(dsci_pkg::CMD_NOP, 2'h0, 14'h0);
    endtask
    task automatic mode(input logic [2:0] b, input logic i, input logic [2:0] c);
        @(posedge clk_in);
        #1;
        {bl, ilv, cl, pgm} = {b, i, c, 1'b1};
        @(posedge clk_in);
        #1;
        pgm = 1'b0;
    endtask
    task automatic wr(input logic [15:0] rv, input logic [15:0] fv, input logic [1:0] l, input logic [1:0] u);
        check("wr_ready", wrdy, 1'b1);
        m.drive(dsci_pkg::CMD_NOP, 2'h0, 14'h0, rv, fv, l, u);
    endtask
    task automatic rd(input logic [13:0] a, input int lat, input int pairs, input logic [63:0] e);
        op(dsci_pkg::CMD_RD, 2'h1, a);
        nop(lat + 1);
        for (int k = 0; k < pairs; k++) begin
            check("read pair", {oe, dq_r, dq_f}, {2'b11, e[63-32*k -: 32]});
            nop(1);
        end
        check("read end", oe, 2'b00);
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        #1;
        rst_b_in = 1'b1;
        check("reset", {act, idle, oe, wrdy, pd, sr, dll_on}, {4'h0, 1'b1, 2'b00, 1'b1, 3'h0});
        emode = 1'b1;
        nop(1);
        emode = 1'b0;
        nop(2);
        check("dll", dll_on, 1'b1);
        op(dsci_pkg::CMD_ACT, 2'h1, 14'h2001);
        op({1'b1, dsci_pkg::CMD_ACT[2:0]}, 2'h2, 14'h0);
        op(dsci_pkg::CMD_ACT, 2'h3, 14'h0);
        nop(3);
        check("activate", act, 4'hA);
        op(dsci_pkg::CMD_PRE, 2'h3, 14'h0);
        nop(4);
        check("precharge", act, 4'h2);
        mode(dsci_pkg::BL4_CODE, 1'b0, dsci_pkg::CL2_CODE);
        op(dsci_pkg::CMD_WR, 2'h1, 14'h0004);
        wr(16'h4444, 16'h5555, 2'b00, 2'b00);
        wr(16'h6666, 16'h7777, 2'b00, 2'b00);
        nop(1);
        mode(dsci_pkg::BL2_CODE, 1'b0, dsci_pkg::CL2_CODE);
        op(dsci_pkg::CMD_WR, 2'h1, 14'h0004);
        wr(16'hAAAA, 16'hBBBB, 2'b01, 2'b10);
        nop(8);
        mode(dsci_pkg::BL4_CODE, 1'b1, dsci_pkg::CL2_CODE);
        rd(14'h0005, 2, 2, {16'h55BB, 16'hAA44, 16'h7777, 16'h6666});
        mode(dsci_pkg::BL2_CODE, 1'b0, dsci_pkg::CL3_CODE);
        rd(14'h0404, 3, 1, {16'hAA44, 16'h55BB, 32'h0});
        for (int i = 0; i < 20 && idle !== 1'b1; i++) nop(1);
        check("auto precharge", {act, idle}, {4'h0, 1'b1});
        if (idle !== 1'b1) give_verdict();
        m.cke_out = 1'b0;
        nop(2);
        check("power down", {pd, sr}, 2'b10);
        m.cke_out = 1'b1;
        nop(3);
        op(dsci_pkg::CMD_REF, 2'h0, 14'h0);
        m.cke_out = 1'b0;
        nop(2);
        check("self refresh", {pd, sr}, 2'b01);
        m.cke_out = 1'b1;
        nop(3);
        check("wake", {pd, sr, idle}, 3'h1);
        give_verdict();
    end
endmodule
`default_nettype wire
